// File: hdl/module_power_reset_gpio.sv
// power, reset, suspend and general i/o logic of the module at its carrier connector
//
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
// ========================================================================
module module_power_reset_gpio (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // carrier inputs, raw
    input wire pwr_mgmt_pkg::board_in_t board_in,
    input wire logic [3:0] gen_in_drive,
    // carrier outputs
    output pwr_mgmt_pkg::board_out_t board_out,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata
);
    import pwr_mgmt_pkg::*;

    // ====================================================================
    // input synchronisers
    localparam int IN_W = $bits(board_in_t);
    // idle levels of the carrier pins: active-low lines high, the two fault flags low;
    // starting the chain from all ones would show a false supply fault and a stray
    // watchdog event in the first cycles after reset
    localparam board_in_t IN_IDLE = '{power_button_n: 1'b1, reset_button_n: 1'b1, power_good: 1'b1,
                                      supply_low: 1'b0, watchdog_expired: 1'b0, pcie_wake_n: 1'b1,
                                      general_wake_n: 1'b1, battery_low_n: 1'b1, over_temp_n: 1'b1,
                                      mgmt_bus_alert_n: 1'b1, gen_in: 4'hF};
    board_in_t raw_in;          // raw inputs, undriven general inputs pulled up
    logic [IN_W-1:0] sync1_ff;  // first stage, read only by the second
    logic [IN_W-1:0] sync2_ff;  // second stage, safe for logic
    board_in_t s_in;            // synchronised view

    // a general input that the carrier leaves floating reads high
    always_comb begin
        raw_in = board_in;
        raw_in.gen_in = board_in.gen_in | ~gen_in_drive;
    end

    // two flops per input; reset value mimics the idle carrier levels, fault flags low
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sync1_ff <= IN_IDLE;
            sync2_ff <= IN_IDLE;
        end else begin
            sync1_ff <= raw_in;
            sync2_ff <= sync1_ff;
        end
    end
    assign s_in = board_in_t'(sync2_ff);

    // ====================================================================
    // edges and conditions
    // the button history resets to the idle high level, so reset makes no false edge
    logic btn_prev_ff;  // button level one cycle ago
    wire btn_rise = s_in.power_button_n & ~btn_prev_ff;
    wire wake_req = ~s_in.pcie_wake_n | ~s_in.general_wake_n;
    wire over_temp = ~s_in.over_temp_n;
    wire alert = ~s_in.mgmt_bus_alert_n;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            btn_prev_ff <= 1'b1;
        end else begin
            btn_prev_ff <= s_in.power_button_n;
        end
    end

    // ====================================================================
    // registers
    logic [7:0] ctrl_ff;            // control bits
    logic [3:0] gen_out_ff;         // general outputs
    logic [NUM_EV-1:0] events_ff;   // sticky events
    logic [7:0] nxt_rdata;
    wire wr_ctrl = reg_wr & (reg_addr == ADDR_CTRL);
    wire wr_gout = reg_wr & (reg_addr == ADDR_GEN_OUT);
    wire wr_ev = reg_wr & (reg_addr == ADDR_EVENTS);
    wire sw_reset = wr_ctrl & reg_wdata[CTRL_SW_RESET];
    wire alert_wakes = ctrl_ff[CTRL_ALERT_WAKE];
    // new events this cycle; set beats a simultaneous clear
    wire [NUM_EV-1:0] ev_set = {s_in.watchdog_expired, alert, over_temp,
                                ~s_in.battery_low_n, wake_req};
    wire [NUM_EV-1:0] ev_clr = wr_ev ? reg_wdata[NUM_EV-1:0] : '0;

    // ctrl and events; software reset bit never stored
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ctrl_ff <= CTRL_RESET;
            events_ff <= '0;
        end else begin
            if (wr_ctrl) begin
                ctrl_ff <= reg_wdata & ~(8'h01 << CTRL_SW_RESET);
            end
            events_ff <= (events_ff & ~ev_clr) | ev_set;
        end
    end

    // ====================================================================
    // power state machine
    pwr_state_t state_ff, nxt_state;
    logic [CNT_W-1:0] cnt_ff;
    wire cnt_done = (cnt_ff == CNT_W'(NOTICE_CYC - 1));
    wire resume = btn_rise | wake_req | (alert & alert_wakes);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_OFF: begin
                if (btn_rise) begin
                    nxt_state = ST_ON;
                end
            end
            ST_ON: begin
                if (ctrl_ff[CTRL_OFF_REQ]) begin
                    nxt_state = ST_NOTICE_OFF;
                end else if (ctrl_ff[CTRL_SLEEP_REQ]) begin
                    nxt_state = ST_NOTICE_SLEEP;
                end
            end
            ST_NOTICE_SLEEP: begin
                if (cnt_done) begin
                    nxt_state = ST_SLEEP;
                end
            end
            ST_NOTICE_OFF: begin
                if (cnt_done) begin
                    nxt_state = ST_OFF;
                end
            end
            ST_SLEEP: begin
                if (resume) begin
                    nxt_state = ST_ON;
                end
            end
            default: nxt_state = ST_OFF;
        endcase
    end

    // suspend request bits stay set; software clears them or a resume suspends again
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_ff <= ST_OFF;
            cnt_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= (nxt_state != state_ff) ? '0 : cnt_ff + 1'b1;
        end
    end

    // ====================================================================
    // reset generation: stretched so a one-cycle cause still shows
    wire rst_cause = ~s_in.reset_button_n | ~s_in.power_good
                     | s_in.supply_low | s_in.watchdog_expired | sw_reset;
    logic [CNT_W-1:0] rst_cnt_ff;
    logic hw_reset_ff;  // carrier reset, active high internally

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            // the stretch also runs from power-on, so the carrier sees a full reset pulse
            rst_cnt_ff <= CNT_W'(RST_STRETCH_CYC);
            hw_reset_ff <= 1'b1;
        end else if (rst_cause) begin
            rst_cnt_ff <= CNT_W'(RST_STRETCH_CYC);
            hw_reset_ff <= 1'b1;
        end else if (rst_cnt_ff != '0) begin
            rst_cnt_ff <= rst_cnt_ff - 1'b1;
        end else begin
            hw_reset_ff <= 1'b0;
        end
    end

    // general outputs cleared by any hardware reset
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            gen_out_ff <= GEN_OUT_RESET;
        end else if (hw_reset_ff) begin
            gen_out_ff <= GEN_OUT_RESET;
        end else if (wr_gout) begin
            gen_out_ff <= reg_wdata[3:0];
        end
    end

    // ====================================================================
    // outputs, all from flops
    // the suspend-to-disk line is tied high: that state is not offered at all
    wire in_notice = (state_ff == ST_NOTICE_SLEEP) | (state_ff == ST_NOTICE_OFF);
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            board_out <= '{carrier_reset_n: 1'b0, suspend_pending_n: 1'b1, sleep_ram_n: 1'b1,
                           sleep_disk_n: 1'b1, soft_off_n: 1'b0, thermal_trip_n: 1'b1,
                           smi_req: 1'b0, gen_out: GEN_OUT_RESET};
        end else begin
            board_out.carrier_reset_n <= ~hw_reset_ff;
            board_out.suspend_pending_n <= ~(in_notice | state_ff == ST_SLEEP);
            board_out.sleep_ram_n <= ~(state_ff == ST_SLEEP);
            board_out.sleep_disk_n <= 1'b1;
            board_out.soft_off_n <= ~(state_ff == ST_OFF);
            board_out.thermal_trip_n <= ~ctrl_ff[CTRL_TRIP];
            board_out.smi_req <= alert & ~alert_wakes;
            board_out.gen_out <= gen_out_ff;
        end
    end

    // ====================================================================
    // read data, one cycle after the strobe
    // reading the events word leaves it alone; only a write of ones clears bits
    always_comb begin
        case (reg_addr)
            ADDR_CTRL: nxt_rdata = ctrl_ff;
            ADDR_GEN_OUT: nxt_rdata = {s_in.gen_in, gen_out_ff};
            ADDR_STATUS: nxt_rdata = {3'h0, over_temp, hw_reset_ff, 3'(state_ff)};
            ADDR_EVENTS: nxt_rdata = {3'h0, events_ff};
            default: nxt_rdata = 8'h00;
        endcase
    end
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? nxt_rdata : 8'h00;
        end
    end

    // ====================================================================
    // checks
    sequence notice_seq;
        in_notice [*2];
    endsequence
    // named steps of power-up and of the end of a notice
    sequence btn_edge_seq;
        !s_in.power_button_n ##1 s_in.power_button_n;
    endsequence
    sequence sleep_entry_seq;
        state_ff == ST_NOTICE_SLEEP && cnt_done;
    endsequence
    sequence off_entry_seq;
        state_ff == ST_NOTICE_OFF && cnt_done;
    endsequence
    gpo_reset_low_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        hw_reset_ff |=> gen_out_ff == GEN_OUT_RESET) else $error("gen out not low in reset");
    btn_wakes_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (state_ff == ST_OFF && btn_rise) |=> state_ff == ST_ON) else $error("button did not power up");
    rst_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        !s_in.reset_button_n |=> ##1 !board_out.carrier_reset_n) else $error("reset not held");
    rst_cause_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        !s_in.power_good |=> hw_reset_ff) else $error("power fail no reset");
    notice_first_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (state_ff == ST_ON && nxt_state == ST_NOTICE_SLEEP) |=> notice_seq) else $error("no notice");
    sleep_ind_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        state_ff == ST_SLEEP |=> !board_out.sleep_ram_n) else $error("sleep ind missing");
    off_ind_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        state_ff == ST_OFF |=> !board_out.soft_off_n) else $error("off ind missing");
    disk_high_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        board_out.sleep_disk_n) else $error("disk ind asserted");
    wake_ok_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (state_ff == ST_SLEEP && wake_req) |=> state_ff == ST_ON) else $error("wake ignored");
    battery_low_n_ev_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        !s_in.battery_low_n |=> events_ff[EV_BATTERY_LOW_N]) else $error("battery_low_n lost");
    smi_cfg_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (alert && !alert_wakes) |=> board_out.smi_req) else $error("smi missing");

    // how long the suspend notice has stood; a counter, since the notice is far
    // longer than any repetition a property should unroll
    logic [CNT_W-1:0] notice_len_ff;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            notice_len_ff <= '0;
        end else if (board_out.suspend_pending_n) begin
            notice_len_ff <= '0;
        end else if (notice_len_ff != '1) begin
            notice_len_ff <= notice_len_ff + 1'b1;
        end
    end

    // reset and general outputs
    // a write outside reset must land on the general outputs
    gpo_write_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (wr_gout && !hw_reset_ff) |=> gen_out_ff == $past(reg_wdata[3:0]))
        else $error("gen out write lost");
    // once every cause is gone and the stretch has run out, reset must lift
    rst_release_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (!rst_cause && rst_cnt_ff == '0) |=> !hw_reset_ff)
        else $error("reset not released");
    sw_rst_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        sw_reset |=> hw_reset_ff)
        else $error("software reset ignored");
    fault_rst_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (s_in.supply_low || s_in.watchdog_expired) |=> hw_reset_ff)
        else $error("fault reset missing");

    // power state and indications
    // a released button in soft-off must start power-up
    btn_edge_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (btn_edge_seq ##0 state_ff == ST_OFF) |=> state_ff == ST_ON)
        else $error("button edge lost");
    // the notice must have stood its full length before the sleep line falls
    notice_len_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        $fell(board_out.sleep_ram_n) |-> notice_len_ff >= CNT_W'(NOTICE_CYC - 1))
        else $error("notice too short");
    off_notice_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (state_ff == ST_ON && nxt_state == ST_NOTICE_OFF) |=> notice_seq)
        else $error("no notice before off");
    sleep_entry_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        sleep_entry_seq |=> state_ff == ST_SLEEP)
        else $error("sleep not entered");
    // the off indication follows the state by one cycle
    off_entry_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        off_entry_seq |=> state_ff == ST_OFF ##1 !board_out.soft_off_n)
        else $error("soft off not entered");
    on_not_off_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        state_ff != ST_OFF |=> board_out.soft_off_n)
        else $error("off ind while on");
    trip_out_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        ctrl_ff[CTRL_TRIP] |=> !board_out.thermal_trip_n)
        else $error("trip output missing");
    // an alert set up to wake must end suspend to ram
    alert_wake_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (state_ff == ST_SLEEP && alert && alert_wakes) |=> state_ff == ST_ON)
        else $error("alert wake ignored");

    // inputs and events
    // with no general input driven, all four must read high two cycles on
    gin_pullup_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        gen_in_drive == 4'h0 |=> ##1 s_in.gen_in == 4'hF)
        else $error("floating input not high");
    temp_event_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        !s_in.over_temp_n |=> events_ff[EV_OVERTEMP])
        else $error("over temp lost");
    // the second stage must only ever copy the first
    sync_chain_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        sync2_ff == $past(sync1_ff))
        else $error("sync chain broken");
endmodule

// File: hdl/pwr_mgmt_pkg.sv
// package: constants, states and carrier structs for the module power/reset block
package pwr_mgmt_pkg;
    // ====================================================================
    // register map (plain port, word addresses)
    localparam logic [3:0] ADDR_CTRL = 4'h0;   // software control
    localparam logic [3:0] ADDR_GEN_OUT = 4'h1; // general outputs
    localparam logic [3:0] ADDR_STATUS = 4'h2; // live state, read only
    localparam logic [3:0] ADDR_EVENTS = 4'h3; // sticky events, write one to clear
    // ctrl fields
    localparam int CTRL_SLEEP_REQ = 0;   // request suspend to ram
    localparam int CTRL_OFF_REQ = 1;     // request soft off
    localparam int CTRL_SW_RESET = 2;    // software reset pulse (self clearing)
    localparam int CTRL_ALERT_WAKE = 3;  // alert wakes instead of raising smi
    localparam int CTRL_TRIP = 4;        // processor entered thermal shutdown
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [3:0] GEN_OUT_RESET = 4'h0;
    // event bit positions
    localparam int EV_WAKE = 0;
    localparam int EV_BATTERY_LOW_N = 1;
    localparam int EV_OVERTEMP = 2;
    localparam int EV_ALERT = 3;
    localparam int EV_WDOG = 4;
    localparam int NUM_EV = 5;
    // ====================================================================
    // timing: suspend notice lead time and reset stretch
    localparam int CLK_MHZ = 125;
    localparam int NOTICE_NS = 1000;
    localparam int NOTICE_CYC = (NOTICE_NS * CLK_MHZ + 999) / 1000;
    localparam int RST_STRETCH_NS = 800;
    localparam int RST_STRETCH_CYC = (RST_STRETCH_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W = 8;
    // power state machine
    typedef enum logic [2:0] {
        ST_OFF, ST_ON, ST_NOTICE_SLEEP, ST_NOTICE_OFF, ST_SLEEP
    } pwr_state_t;
    // synchronised carrier inputs
    typedef struct packed {
        logic power_button_n;
        logic reset_button_n;
        logic power_good;
        logic supply_low;
        logic watchdog_expired;
        logic pcie_wake_n;
        logic general_wake_n;
        logic battery_low_n;
        logic over_temp_n;
        logic mgmt_bus_alert_n;
        logic [3:0] gen_in;
    } board_in_t;
    // indications to the carrier
    typedef struct packed {
        logic carrier_reset_n;
        logic suspend_pending_n;
        logic sleep_ram_n;
        logic sleep_disk_n;
        logic soft_off_n;
        logic thermal_trip_n;
        logic smi_req;
        logic [3:0] gen_out;
    } board_out_t;
endpackage

// File: verification/carrier_board_model.sv
// carrier board model: supply, buttons and sensors seen by the module
`timescale 1ns/1ns
module carrier_board_model (
    // clock
    input wire logic clk_sys,
    // pins toward the module
    output pwr_mgmt_pkg::board_in_t board_in,
    output logic [3:0] gen_in_drive
);
    import pwr_mgmt_pkg::*;
    // ====================================================================
    // pin levels; idle active-low lines rest at their pull-up level
    board_in_t pins = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'h0};
    logic [3:0] drive = 4'h0; // general inputs that the board really drives
    logic [3:0] float_pat = 4'hA; // undriven bits toggle, so only the pull-up can read high
    always @(posedge clk_sys) begin
        float_pat <= ~float_pat;
    end
    // undriven general inputs carry the toggling pattern, never a stale value
    always_comb begin
        board_in = pins;
        board_in.gen_in = (pins.gen_in & drive) | (float_pat & ~drive);
    end
    assign gen_in_drive = drive;
    // press and release the power button; release gives the rising edge
    task automatic press_power(input int n);
        @(posedge clk_sys);
        pins.power_button_n <= 1'b0;
        repeat (n) @(posedge clk_sys);
        pins.power_button_n <= 1'b1;
    endtask
endmodule

// File: verification/module_power_reset_gpio_tb.sv
// self-checking bench for the module power, reset and general i/o block
`timescale 1ns/1ns
module module_power_reset_gpio_tb;
    import pwr_mgmt_pkg::*;
    // ====================================================================
    // clock, reset and register port
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    board_in_t board_in;
    board_out_t bo;
    logic [3:0] gen_in_drive;
    int failures = 0;
    int n_checks = 0;
    logic rd_q = 1'b0; // read strobe one cycle late
    logic [7:0] exp_q[$]; // expected read data in order
    logic [31:0] rnd = 32'hF1B5;
    logic [3:0] go; // last general output value written
    always #4 clk_sys = ~clk_sys;
    carrier_board_model cb (.clk_sys(clk_sys), .board_in(board_in), .gen_in_drive(gen_in_drive));
    module_power_reset_gpio dut (.clk_sys(clk_sys), .resetn(resetn), .board_in(board_in),
        .gen_in_drive(gen_in_drive), .board_out(bo), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    // ====================================================================
    // helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    // the reader notes the expected word; the monitor compares it
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        exp_q.push_back(e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(posedge clk_sys);
    endtask
    always @(posedge clk_sys) begin
        rd_q <= reg_rd;
        if (rd_q) begin
            check(reg_rdata, exp_q.pop_front());
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // bounded wait for the carrier reset to be let go
    task automatic wait_up();
        for (int i = 0; i < 400 && bo.carrier_reset_n !== 1'b1; i++) cyc(1);
        check({7'h00, bo.carrier_reset_n}, 8'h01);
    endtask
    task automatic wrap_up();
        if (failures == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // watchdog: the whole sequence takes well under 20000 cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        wrap_up();
    end
    // ====================================================================
    // main sequence
    initial begin
        repeat (12) @(posedge clk_sys);
        resetn <= 1'b1;
        cyc(2);
        check({4'h0, bo.gen_out}, 8'h00);
        check({7'h00, bo.sleep_disk_n}, 8'h01);
        check({7'h00, bo.soft_off_n}, 8'h00);
        rd(ADDR_STATUS, 8'h08);
        cb.press_power(10);
        wait_up();
        rd(ADDR_STATUS, 8'h01);
        // general outputs and inputs, undriven inputs must read high
        rnd = xs(rnd);
        go = rnd[3:0];
        cb.drive <= rnd[7:4];
        cb.pins.gen_in <= rnd[11:8];
        wr(ADDR_GEN_OUT, {4'h0, go});
        cyc(4);
        check({4'h0, bo.gen_out}, {4'h0, go});
        rd(ADDR_GEN_OUT, {(rnd[11:8] & rnd[7:4]) | ~rnd[7:4], go});
        // suspend to ram: notice first, then the sleep indication
        wr(ADDR_CTRL, 8'h01);
        cyc(5);
        check({6'h00, bo.suspend_pending_n, bo.sleep_ram_n}, 8'h01);
        cyc(130);
        check({7'h00, bo.sleep_ram_n}, 8'h00);
        rd(ADDR_STATUS, 8'h04);
        wr(ADDR_CTRL, 8'h00);
        cb.pins.pcie_wake_n <= 1'b0;
        cyc(6);
        cb.pins.pcie_wake_n <= 1'b1;
        cyc(6);
        check({7'h00, bo.sleep_ram_n}, 8'h01);
        rd(ADDR_STATUS, 8'h01);
        // sticky events from battery, temperature and alert inputs
        wr(ADDR_EVENTS, 8'h1F);
        cb.pins.battery_low_n <= 1'b0;
        cb.pins.over_temp_n <= 1'b0;
        cb.pins.mgmt_bus_alert_n <= 1'b0;
        cyc(5);
        check({7'h00, bo.smi_req}, 8'h01);
        rd(ADDR_STATUS, 8'h11);
        rd(ADDR_EVENTS, 8'h0E);
        cb.pins.battery_low_n <= 1'b1;
        cb.pins.over_temp_n <= 1'b1;
        cb.pins.mgmt_bus_alert_n <= 1'b1;
        cyc(5);
        check({7'h00, bo.smi_req}, 8'h00);
        wr(ADDR_EVENTS, 8'h1F);
        rd(ADDR_EVENTS, 8'h00);
        // alert set up to wake: no smi, and it ends suspend to ram
        wr(ADDR_CTRL, 8'h09);
        cyc(135);
        check({7'h00, bo.sleep_ram_n}, 8'h00);
        wr(ADDR_CTRL, 8'h08);
        cb.pins.mgmt_bus_alert_n <= 1'b0;
        cyc(6);
        check({6'h00, bo.smi_req, bo.sleep_ram_n}, 8'h01);
        cb.pins.mgmt_bus_alert_n <= 1'b1;
        rd(ADDR_STATUS, 8'h01);
        // the general wake input ends suspend to ram as well
        wr(ADDR_CTRL, 8'h01);
        cyc(135);
        wr(ADDR_CTRL, 8'h00);
        cb.pins.general_wake_n <= 1'b0;
        cyc(6);
        cb.pins.general_wake_n <= 1'b1;
        cyc(6);
        rd(ADDR_STATUS, 8'h01);
        // thermal trip and an unmapped address
        wr(ADDR_CTRL, 8'h10);
        cyc(3);
        check({7'h00, bo.thermal_trip_n}, 8'h00);
        wr(ADDR_CTRL, 8'h00);
        rd(4'hF, 8'h00);
        // soft off through its notice
        wr(ADDR_CTRL, 8'h02);
        cyc(5);
        check({6'h00, bo.suspend_pending_n, bo.soft_off_n}, 8'h01);
        cyc(130);
        check({7'h00, bo.soft_off_n}, 8'h00);
        wr(ADDR_CTRL, 8'h00);
        cb.press_power(10);
        wait_up();
        // every carrier reset cause, one after another
        for (int k = 0; k < 5; k++) begin
            wr(ADDR_GEN_OUT, 8'h0F);
            case (k)
                0: cb.pins.reset_button_n <= 1'b0;
                1: cb.pins.power_good <= 1'b0;
                2: cb.pins.supply_low <= 1'b1;
                3: cb.pins.watchdog_expired <= 1'b1;
                default: wr(ADDR_CTRL, 8'h04);
            endcase
            cyc(60);
            check({7'h00, bo.carrier_reset_n}, 8'h00);
            cb.pins.reset_button_n <= 1'b1;
            cb.pins.power_good <= 1'b1;
            cb.pins.supply_low <= 1'b0;
            cb.pins.watchdog_expired <= 1'b0;
            cyc(2);
            check({4'h0, bo.gen_out}, 8'h00);
            cb.press_power(10);
            wait_up();
        end
        cyc(5);
        wrap_up();
    end
endmodule
